//--- logic/idle_sleep_controller.sv
// Start-up sequencing and idle-to-sleep power control.
// Assumes NRST comes from the power-on detector and CLK from the internal oscillator.
`timescale 1ns/1ns
module idle_sleep_controller
	import idle_sleep_pkg::*;
#(
	parameter int unsigned STEP_CYCLES_P = STEP_CYCLES,
	parameter int unsigned INIT_CYCLES_P = INIT_CYCLES
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic SUPPLY_OK,
	input wire idle_sleep_pkg::bus_lines_t LINES,
	input wire logic FUNC_BUSY,
	input wire idle_sleep_pkg::interval_wr_t INTERVAL_WR,
	input wire logic NVM_FAST,
	output idle_sleep_pkg::mode_t MODE,
	output logic CORE_RST_N,
	output logic INIT_BUSY,
	output logic CFG_READY,
	output logic OSC_EN,
	output logic SLEEPING,
	output logic NVM_CLK_TICK,
	output logic [idle_sleep_pkg::STEP_W-1:0] INTERVAL,
	output logic [idle_sleep_pkg::STEP_W-1:0] IDLE_STEPS
);
	import idle_sleep_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		mode_t mode;
		logic [CNT_W-1:0] cnt;
		logic [STEP_W-1:0] steps;
		logic [STEP_W-1:0] interval;
		logic core_rst_n;
		logic cfg_ready;
		logic nvm_phase;
		logic nvm_tick;
	} ctrl_state_t;

	ctrl_state_t state;
	ctrl_state_t next_state;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic supply_s;
	bus_lines_t lines_s;

	sync2 #(
		.W(1),
		.RST_VAL(1'b0)
	) u_supply_sync (
		.clk(CLK),
		.nrst(NRST),
		.d(SUPPLY_OK),
		.q(supply_s)
	);

	// Idle lines rest high, so reset to high avoids a false wake
	sync2 #(
		.W(2),
		.RST_VAL(2'b11)
	) u_lines_sync (
		.clk(CLK),
		.nrst(NRST),
		.d(LINES),
		.q(lines_s)
	);

	// ------------------------------------------------------------
	// Idle step prescaler
	// ------------------------------------------------------------
	logic bus_idle;
	logic idle_run;
	logic step_tick;
	logic [STEP_W-1:0] steps_inc;
	logic [STEP_W-1:0] wr_clamped;

	assign bus_idle = lines_s.scl & lines_s.sda & ~FUNC_BUSY;
	assign idle_run = bus_idle & (state.mode == MODE_ACTIVE);

	step_timer #(
		.STEP_CYCLES(STEP_CYCLES_P)
	) u_step_timer (
		.clk(CLK),
		.nrst(NRST),
		.run(idle_run),
		.tick(step_tick)
	);

	assign steps_inc = state.steps + STEP_W'(1);

	// Out-of-range writes saturate rather than wrap to a tiny interval
	always_comb begin
		if (INTERVAL_WR.steps < STEPS_MIN) begin
			wr_clamped = STEPS_MIN;
		end else if (INTERVAL_WR.steps > STEPS_RESET) begin
			wr_clamped = STEPS_RESET;
		end else begin
			wr_clamped = INTERVAL_WR.steps;
		end
	end

	// ------------------------------------------------------------
	// Mode sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.nvm_tick = 1'b0;
		if (!supply_s) begin
			// Brown-out restarts the whole sequence
			next_state.mode = MODE_POR_HOLD;
			next_state.cnt = CNT_RESET;
			next_state.steps = '0;
			next_state.interval = STEPS_RESET;
			next_state.core_rst_n = 1'b0;
			next_state.cfg_ready = 1'b0;
			next_state.nvm_phase = 1'b0;
		end else begin
			unique case (state.mode)
				MODE_POR_HOLD: begin
					if (state.cnt == CNT_W'(POR_HOLD_CYCLES - 1)) begin
						next_state.mode = MODE_INIT;
						next_state.cnt = CNT_RESET;
						next_state.core_rst_n = 1'b1;
					end else begin
						next_state.cnt = state.cnt + CNT_W'(1);
					end
				end
				MODE_INIT: begin
					// Setting writes are ignored here
					if (state.cnt == CNT_W'(INIT_CYCLES_P - 1)) begin
						next_state.mode = MODE_ACTIVE;
						next_state.cnt = CNT_RESET;
						next_state.cfg_ready = 1'b1;
					end else begin
						next_state.cnt = state.cnt + CNT_W'(1);
					end
				end
				MODE_ACTIVE: begin
					if (INTERVAL_WR.we) begin
						next_state.interval = wr_clamped;
					end
					if (!bus_idle) begin
						next_state.steps = '0;
					end else if (step_tick) begin
						if (steps_inc >= state.interval) begin
							next_state.mode = MODE_SLEEP;
							next_state.steps = '0;
						end else begin
							next_state.steps = steps_inc;
						end
					end
					next_state.nvm_phase = ~state.nvm_phase;
					next_state.nvm_tick = NVM_FAST | state.nvm_phase;
				end
				MODE_SLEEP: begin
					if (!lines_s.scl || !lines_s.sda) begin
						next_state.mode = MODE_ACTIVE;
						next_state.steps = '0;
					end
				end
				default: begin
					next_state.mode = MODE_POR_HOLD;
					next_state.cnt = CNT_RESET;
					next_state.core_rst_n = 1'b0;
					next_state.cfg_ready = 1'b0;
				end
			endcase
		end
	end

	// Single oscillator domain for every register
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state.mode <= MODE_POR_HOLD;
			state.cnt <= CNT_RESET;
			state.steps <= '0;
			state.interval <= STEPS_RESET;
			state.core_rst_n <= 1'b0;
			state.cfg_ready <= 1'b0;
			state.nvm_phase <= 1'b0;
			state.nvm_tick <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Raw pins restart the oscillator: no clock runs to sample them in sleep
	assign OSC_EN = (state.mode != MODE_SLEEP) | ~LINES.scl | ~LINES.sda;
	assign MODE = state.mode;
	assign CORE_RST_N = state.core_rst_n;
	assign INIT_BUSY = (state.mode == MODE_INIT);
	assign CFG_READY = state.cfg_ready;
	assign SLEEPING = (state.mode == MODE_SLEEP);
	assign NVM_CLK_TICK = state.nvm_tick;
	assign INTERVAL = state.interval;
	assign IDLE_STEPS = state.steps;
endmodule // idle_sleep_controller

//--- logic/idle_sleep_pkg.sv
// Shared constants and types of the idle/sleep and start-up controller.
// Assumes one free-running oscillator clock of CLK_PERIOD_NS.
package idle_sleep_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned STEP_TIME_US = 4096;
	localparam int unsigned MAX_IDLE_US = 33000000;
	localparam int unsigned INIT_TIME_MS = 14;
	localparam int unsigned POR_HOLD_US = 160;
	localparam int unsigned STEP_CYCLES = STEP_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned INIT_CYCLES = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned POR_HOLD_CYCLES = (POR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MAX_STEPS = MAX_IDLE_US / STEP_TIME_US;

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int STEP_W = 13;
	localparam int CNT_W = 20;
	localparam logic [STEP_W-1:0] STEPS_MIN = 13'h0001;
	localparam logic [STEP_W-1:0] STEPS_RESET = STEP_W'(MAX_STEPS);
	localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_POR_HOLD = 4'h1,
		MODE_INIT = 4'h2,
		MODE_ACTIVE = 4'h4,
		MODE_SLEEP = 4'h8
	} mode_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_t;

	typedef struct packed {
		logic we;
		logic [STEP_W-1:0] steps;
	} interval_wr_t;

endpackage

//--- logic/sync2.sv
// Two-flop synchroniser for asynchronous levels.
// Assumes the reader tolerates two cycles of latency.
`timescale 1ns/1ns
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] out;
	} sync_state_t;

	sync_state_t state;
	sync_state_t next_state;

	// First stage feeds only the second stage
	always_comb begin
		next_state.meta = d;
		next_state.out = state.meta;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= {RST_VAL, RST_VAL};
		end else begin
			state <= next_state;
		end
	end

	assign q = state.out;
endmodule // sync2

//--- logic/step_timer.sv
// Prescaler that emits one pulse per idle step while run stays high.
// Assumes run drops whenever the idle condition breaks.
`timescale 1ns/1ns
module step_timer #(
	parameter int unsigned STEP_CYCLES = 81920
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic run,
	output logic tick
);
	localparam int CW = $clog2(STEP_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} timer_state_t;

	timer_state_t state;
	timer_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (!run) begin
			next_state.cnt = '0;
		end else if (state.cnt == CW'(STEP_CYCLES - 1)) begin
			next_state.cnt = '0;
			next_state.tick = 1'b1;
		end else begin
			next_state.cnt = state.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;
endmodule // step_timer

//--- bench/idle_sleep_properties.sv
// Timing checker for the idle/sleep controller.
// Assumes it is bound onto the controller's top module.
`timescale 1ns/1ns
module idle_sleep_properties
	import idle_sleep_pkg::*;
#(
	parameter int unsigned INIT_CYCLES_P = 8
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic SUPPLY_OK,
	input wire idle_sleep_pkg::bus_lines_t LINES,
	input wire logic FUNC_BUSY,
	input wire idle_sleep_pkg::interval_wr_t INTERVAL_WR,
	input wire logic NVM_FAST,
	input wire idle_sleep_pkg::mode_t MODE,
	input wire logic CORE_RST_N,
	input wire logic INIT_BUSY,
	input wire logic OSC_EN,
	input wire logic SLEEPING,
	input wire logic NVM_CLK_TICK,
	input wire logic [idle_sleep_pkg::STEP_W-1:0] INTERVAL,
	input wire logic [idle_sleep_pkg::STEP_W-1:0] IDLE_STEPS
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	int unsigned init_cnt;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			init_cnt <= 0;
		else
			init_cnt <= INIT_BUSY ? init_cnt + 1 : 0;
	end
	osc_gate_a: assert property (OSC_EN == !(SLEEPING && LINES.scl && LINES.sda))
		else $error("oscillator enable wrong");
	line_wake_a: assert property ((!(LINES.scl && LINES.sda))[*3] |=> MODE != MODE_SLEEP)
		else $error("no wake on low line");
	sleep_entry_a: assert property ($rose(SLEEPING) |-> $past(MODE) == MODE_ACTIVE)
		else $error("sleep not from active");
	busy_clear_a: assert property (FUNC_BUSY && MODE == MODE_ACTIVE |=> IDLE_STEPS == 0)
		else $error("idle steps not cleared");
	write_take_a: assert property (MODE == MODE_ACTIVE && INTERVAL_WR.we &&
		INTERVAL_WR.steps inside {[STEPS_MIN:STEPS_RESET]} |=> INTERVAL == $past(INTERVAL_WR.steps))
		else $error("interval write lost");
	write_refuse_a: assert property (MODE inside {MODE_INIT, MODE_SLEEP} |=> $stable(INTERVAL))
		else $error("interval changed outside active");
	init_len_a: assert property ($fell(INIT_BUSY) && MODE == MODE_ACTIVE |-> init_cnt == INIT_CYCLES_P)
		else $error("init period length wrong");
	nvm_fast_a: assert property ((MODE == MODE_ACTIVE && NVM_FAST)[*3] |-> NVM_CLK_TICK)
		else $error("memory tick missing");
	nvm_half_a: assert property (NVM_CLK_TICK && !NVM_FAST && !$past(NVM_FAST) |=> !NVM_CLK_TICK)
		else $error("memory tick too fast");
	brown_out_a: assert property ((!SUPPLY_OK)[*3] |=>
		MODE == MODE_POR_HOLD && !CORE_RST_N && INTERVAL == STEPS_RESET)
		else $error("supply loss not reset");
endmodule // idle_sleep_properties

//--- bench/mcu_master_model.sv
// Bus master model: drives the two lines and interval writes.
// Assumes the lines are pulled up when released.
`timescale 1ns/1ns
module mcu_master_model
	import idle_sleep_pkg::*;
(
	input wire logic clk,
	input wire logic cfg_ready,
	output idle_sleep_pkg::bus_lines_t lines,
	output idle_sleep_pkg::interval_wr_t wr
);
	initial begin
		lines = '{scl: 1'b1, sda: 1'b1};
		wr = '0;
	end
	// Early writes only to probe refusal
	task automatic write_interval(input logic [STEP_W-1:0] steps, input bit early);
		if (!early)
			wait (cfg_ready === 1'b1);
		@(posedge clk);
		wr <= '{we: 1'b1, steps: steps};
		@(posedge clk);
		wr <= '{we: 1'b0, steps: ~steps};
	endtask
	task automatic drive_lines(input logic scl, input logic sda);
		@(posedge clk);
		lines <= '{scl: scl, sda: sda};
	endtask
endmodule // mcu_master_model

//--- bench/idle_sleep_controller_test.sv
// Self-checking bench for the idle/sleep controller.
// Assumes short step and init counts set at the instance.
`timescale 1ns/1ns
module idle_sleep_controller_test;
	import idle_sleep_pkg::*;
	logic CLK = 0, NRST = 0, SUPPLY_OK = 1, FUNC_BUSY = 1, NVM_FAST = 0;
	bus_lines_t LINES;
	interval_wr_t INTERVAL_WR;
	mode_t MODE;
	logic CORE_RST_N, INIT_BUSY, CFG_READY, OSC_EN, SLEEPING, NVM_CLK_TICK;
	logic [STEP_W-1:0] INTERVAL, IDLE_STEPS;
	int n_mismatch = 0, comparisons = 0, cyc = 0, n;
	typedef struct {logic [STEP_W-1:0] wr; logic [STEP_W-1:0] exp;} row_t;
	row_t rows[5] = '{'{13'h0005, 13'h0005}, '{13'h0000, 13'h0001}, '{13'h1f78, 13'h1f78},
		'{13'h1fff, 13'h1f78}, '{13'h0001, 13'h0001}};
	idle_sleep_controller #(.STEP_CYCLES_P(4), .INIT_CYCLES_P(8)) idle_sleep_controller_i (
		.CLK(CLK), .NRST(NRST), .SUPPLY_OK(SUPPLY_OK), .LINES(LINES), .FUNC_BUSY(FUNC_BUSY),
		.INTERVAL_WR(INTERVAL_WR), .NVM_FAST(NVM_FAST), .MODE(MODE), .CORE_RST_N(CORE_RST_N),
		.INIT_BUSY(INIT_BUSY), .CFG_READY(CFG_READY), .OSC_EN(OSC_EN), .SLEEPING(SLEEPING),
		.NVM_CLK_TICK(NVM_CLK_TICK), .INTERVAL(INTERVAL), .IDLE_STEPS(IDLE_STEPS)
	);
	mcu_master_model mcu_master_model_i (.clk(CLK), .cfg_ready(CFG_READY), .lines(LINES), .wr(INTERVAL_WR));
	initial forever #25 CLK = ~CLK;
	task automatic check(input string what, input logic [STEP_W-1:0] exp, input logic [STEP_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard, well above the ~3300 cycles needed
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge CLK);
		#1 check("mode", STEP_W'(MODE_POR_HOLD), STEP_W'(MODE));
		check("interval", STEPS_RESET, INTERVAL);
		check("core rst", 0, CORE_RST_N);
		@(posedge CLK) NRST <= 1;
		n = 0;
		while (CORE_RST_N !== 1'b1 && n < 4000) begin
			@(posedge CLK);
			#1 n++;
		end
		check("por hold", 1, n >= POR_HOLD_CYCLES && n <= POR_HOLD_CYCLES + 4);
		mcu_master_model_i.write_interval(13'h0005, 1);
		#1 check("interval", STEPS_RESET, INTERVAL);
		foreach (rows[i]) begin
			mcu_master_model_i.write_interval(rows[i].wr, 0);
			#1 check("interval", rows[i].exp, INTERVAL);
		end
		mcu_master_model_i.write_interval(13'h0002, 0);
		@(posedge CLK) FUNC_BUSY <= 0;
		repeat (6) @(posedge CLK);
		FUNC_BUSY <= 1;
		@(posedge CLK) FUNC_BUSY <= 0;
		#1 check("steps", 0, IDLE_STEPS);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			while (SLEEPING !== 1'b1 && n < 50) begin
				@(posedge CLK);
				#1 n++;
			end
			check("sleep delay", 1, n >= 8 && n <= 13);
			check("osc", 0, OSC_EN);
			mcu_master_model_i.drive_lines(k[0], !k[0]);
			#1 check("osc", 1, OSC_EN);
			repeat (3) @(posedge CLK);
			#1 check("mode", STEP_W'(MODE_ACTIVE), STEP_W'(MODE));
			mcu_master_model_i.drive_lines(1, 1);
		end
		@(posedge CLK) FUNC_BUSY <= 1;
		for (int f = 1; f >= 0; f--) begin
			@(posedge CLK) NVM_FAST <= f[0];
			repeat (3) @(posedge CLK);
			n = 0;
			repeat (8) begin
				@(posedge CLK);
				#1 n += NVM_CLK_TICK;
			end
			check("nvm ticks", f ? 8 : 4, STEP_W'(n));
		end
		@(posedge CLK) SUPPLY_OK <= 0;
		repeat (4) @(posedge CLK);
		#1 check("mode", STEP_W'(MODE_POR_HOLD), STEP_W'(MODE));
		check("interval", STEPS_RESET, INTERVAL);
		report_and_stop();
	end
endmodule // idle_sleep_controller_test
bind idle_sleep_controller idle_sleep_properties #(.INIT_CYCLES_P(INIT_CYCLES_P)) idle_sleep_properties_i (
	.CLK(CLK), .NRST(NRST), .SUPPLY_OK(SUPPLY_OK), .LINES(LINES), .FUNC_BUSY(FUNC_BUSY),
	.INTERVAL_WR(INTERVAL_WR), .NVM_FAST(NVM_FAST), .MODE(MODE), .CORE_RST_N(CORE_RST_N),
	.INIT_BUSY(INIT_BUSY), .OSC_EN(OSC_EN), .SLEEPING(SLEEPING), .NVM_CLK_TICK(NVM_CLK_TICK),
	.INTERVAL(INTERVAL), .IDLE_STEPS(IDLE_STEPS)
);
